// ---- pcg_clk_map.svh ----
/*
 * register map of the peripheral clock gating block: offsets, field
 * positions, writable masks and reset values.
 * assumes byte addressing on a 32-bit APB, one word per register.
 */
`ifndef PCG_CLK_MAP_SVH
`define PCG_CLK_MAP_SVH

// register byte offsets
`define PCG_FAST_OFS        12'h014
`define PCG_SECOND_OFS      12'h018

// fast bus gate register fields
`define PCG_CONVERTER_BIT   12
`define PCG_DIVIDER_BIT     7
`define PCG_CHECKSUM_BIT    6
`define PCG_ROOT_BIT        5
`define PCG_FLASH_BIT       4
`define PCG_RAM_SLEEP_BIT   2
`define PCG_DMA_BIT         0

// second bus gate register fields
`define PCG_SERIAL_BIT      14
`define PCG_TIMER_B_BIT     13
`define PCG_TIMER_A_BIT     12

// writable bits and reset values
`define PCG_FAST_MASK       32'h0000_10f5
`define PCG_SECOND_MASK     32'h0000_7000
`define PCG_FAST_RST        32'h0000_0014
`define PCG_SECOND_RST      32'h0000_0000

`endif

// ---- pcg_pkg.sv ----
/*
 * types of the peripheral clock gating block.
 * assumes nothing of its surroundings.
 */
package pcg_pkg;

    typedef enum logic [1:0]
    {
        PCG_ST_IDLE = 2'h0,
        PCG_ST_ACK  = 2'h1
    } pcg_state_t;

    typedef struct packed
    {
        pcg_state_t  st;
        logic [31:0] fast;
        logic [31:0] second;
        logic [31:0] rdata;
        logic        ready;
        logic        err;
    } pcg_regs_t;

    typedef struct packed
    {
        logic converter;
        logic divider;
        logic checksum;
        logic root;
        logic flash;
        logic ram;
        logic dma;
        logic serial;
        logic timer_b;
        logic timer_a;
    } pcg_gates_t;

endpackage

// ---- pcg_gate_if.sv ----
/*
 * carrier from the register file to the gate stage: both enable
 * words and the sleep level.
 * assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface pcg_gate_if;
    logic [31:0] fast_en;
    logic [31:0] second_en;
    logic        sleep;

    modport ctrl (output fast_en, output second_en, output sleep);
    modport gate (input fast_en, input second_en, input sleep);
endinterface

// ---- pcg_gate_stage.sv ----
/*
 * gate stage: turns the enable words into one registered clock
 * enable per peripheral.
 * assumes the enables and sleep are synchronous to clock_i.
 */
`timescale 1ns/1ps
`include "pcg_clk_map.svh"
module pcg_gate_stage
(
    // clock and reset
    input  wire logic              clock_i,
    input  wire logic              rst_i,
    // enables in
    pcg_gate_if.gate               en_if,
    // registered gates out
    output pcg_pkg::pcg_gates_t    gates_o
);

    pcg_pkg::pcg_gates_t gates_d;
    pcg_pkg::pcg_gates_t gates_q;

    always_comb
    begin
        gates_d           = gates_q;
        gates_d.converter = en_if.fast_en[`PCG_CONVERTER_BIT];
        gates_d.divider   = en_if.fast_en[`PCG_DIVIDER_BIT];
        gates_d.checksum  = en_if.fast_en[`PCG_CHECKSUM_BIT];
        gates_d.root      = en_if.fast_en[`PCG_ROOT_BIT];
        gates_d.flash     = en_if.fast_en[`PCG_FLASH_BIT];
        // awake the ram always runs; the bit only matters in sleep
        gates_d.ram       = !en_if.sleep
                          || en_if.fast_en[`PCG_RAM_SLEEP_BIT];
        gates_d.dma       = en_if.fast_en[`PCG_DMA_BIT];
        gates_d.serial    = en_if.second_en[`PCG_SERIAL_BIT];
        gates_d.timer_b   = en_if.second_en[`PCG_TIMER_B_BIT];
        gates_d.timer_a   = en_if.second_en[`PCG_TIMER_A_BIT];
    end

    // reset state mirrors the register reset values
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            gates_q       <= '0;
            gates_q.flash <= 1'b1;
            gates_q.ram   <= 1'b1;
        end
        else
        begin
            gates_q <= gates_d;
        end
    end

    assign gates_o = gates_q;

endmodule

// ---- pcg_clock_gate.sv ----
/*
 * peripheral clock gating: APB slave holding the two gate registers
 * and driving one clock enable per peripheral.
 * assumes an APB master on clock_i and peripherals that use the
 * enables as clock gates; sleep_i is synchronous to clock_i.
 */
// Decided for this implementation: the APB interface to the registers.
// Notes on behaviour
// - fast bit 12 gates converter clock
// - fast bit 7 gates divider clock
// - fast bit 6 gates checksum clock
// - fast bit 5 gates square-root clock
// - fast bit 4 gates flash interface clock
// - fast bit 2 keeps ram clock in sleep
// - fast bit 0 gates dma clock
// - second bit 14 gates serial port clock
// - second bit 13 gates timer b clock
// - second bit 12 gates timer a clock
`timescale 1ns/1ps
`include "pcg_clk_map.svh"
module pcg_clock_gate
#(
    parameter int ADDR_W = 12
)
(
    // clock and reset
    input  wire logic              clock_i,
    input  wire logic              rst_i,
    // apb slave
    input  wire logic              psel_i,
    input  wire logic              penable_i,
    input  wire logic              pwrite_i,
    input  wire logic [ADDR_W-1:0] paddr_i,
    input  wire logic [31:0]       pwdata_i,
    input  wire logic [3:0]        pstrb_i,
    output logic [31:0]            prdata_o,
    output logic                   pready_o,
    output logic                   pslverr_o,
    // power state
    input  wire logic              sleep_i,
    // peripheral clock enables
    output logic                   converter_clk_on_o,
    output logic                   divider_clk_on_o,
    output logic                   checksum_clk_on_o,
    output logic                   root_unit_clk_on_o,
    output logic                   flash_if_clk_on_o,
    output logic                   ram_clk_on_o,
    output logic                   dma_clk_on_o,
    output logic                   serial_port_one_clk_on_o,
    output logic                   adv_timer_b_clk_on_o,
    output logic                   adv_timer_a_clk_on_o
);

    pcg_pkg::pcg_regs_t  st_d;
    pcg_pkg::pcg_regs_t  st_q;
    pcg_pkg::pcg_gates_t gates;
    pcg_gate_if          en_if ();

    // one-hot select: bit 0 fast register, bit 1 second register
    function automatic logic [1:0] reg_sel(input logic [ADDR_W-1:0] a);
        logic [1:0] s;
        s    = 2'h0;
        s[0] = (a == ADDR_W'(`PCG_FAST_OFS));
        s[1] = (a == ADDR_W'(`PCG_SECOND_OFS));
        return s;
    endfunction

    // byte-lane merge; reserved bits never leave their reset value
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  strb,
                                          input logic [31:0] mask);
        logic [31:0] lanes;
        lanes = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
        return (old & ~(lanes & mask)) | (wd & lanes & mask);
    endfunction

    logic [1:0] sel;
    logic       fire;

    assign sel  = reg_sel(paddr_i);
    assign fire = psel_i && penable_i && st_q.ready;

    always_comb
    begin
        st_d = st_q;
        case (st_q.st)
            pcg_pkg::PCG_ST_IDLE:
            begin
                // setup phase: answer is ready in the first access cycle
                if (psel_i && !penable_i)
                begin
                    st_d.st    = pcg_pkg::PCG_ST_ACK;
                    st_d.ready = 1'b1;
                    st_d.err   = (sel == 2'h0);
                    st_d.rdata = 32'h0;
                    if (!pwrite_i && sel[0])
                    begin
                        st_d.rdata = st_q.fast;
                    end
                    if (!pwrite_i && sel[1])
                    begin
                        st_d.rdata = st_q.second;
                    end
                end
            end
            pcg_pkg::PCG_ST_ACK:
            begin
                if (fire)
                begin
                    if (pwrite_i && sel[0])
                    begin
                        st_d.fast = merge(st_q.fast, pwdata_i, pstrb_i,
                                          `PCG_FAST_MASK);
                    end
                    if (pwrite_i && sel[1])
                    begin
                        st_d.second = merge(st_q.second, pwdata_i, pstrb_i,
                                            `PCG_SECOND_MASK);
                    end
                    st_d.st    = pcg_pkg::PCG_ST_IDLE;
                    st_d.ready = 1'b0;
                    st_d.err   = 1'b0;
                    st_d.rdata = 32'h0;
                end
                else if (!psel_i)
                begin
                    // master dropped the transfer: abandon quietly
                    st_d.st    = pcg_pkg::PCG_ST_IDLE;
                    st_d.ready = 1'b0;
                    st_d.err   = 1'b0;
                    st_d.rdata = 32'h0;
                end
            end
            default:
            begin
                st_d.st    = pcg_pkg::PCG_ST_IDLE;
                st_d.ready = 1'b0;
                st_d.err   = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            st_q        <= '0;
            st_q.st     <= pcg_pkg::PCG_ST_IDLE;
            st_q.fast   <= `PCG_FAST_RST;
            st_q.second <= `PCG_SECOND_RST;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign en_if.fast_en   = st_q.fast;
    assign en_if.second_en = st_q.second;
    assign en_if.sleep     = sleep_i;

    pcg_gate_stage u_gate
    (
        .clock_i (clock_i),
        .rst_i   (rst_i),
        .en_if   (en_if),
        .gates_o (gates)
    );

    assign prdata_o                 = st_q.rdata;
    assign pready_o                 = st_q.ready;
    assign pslverr_o                = st_q.err;
    assign converter_clk_on_o       = gates.converter;
    assign divider_clk_on_o         = gates.divider;
    assign checksum_clk_on_o        = gates.checksum;
    assign root_unit_clk_on_o       = gates.root;
    assign flash_if_clk_on_o        = gates.flash;
    assign ram_clk_on_o             = gates.ram;
    assign dma_clk_on_o             = gates.dma;
    assign serial_port_one_clk_on_o = gates.serial;
    assign adv_timer_b_clk_on_o     = gates.timer_b;
    assign adv_timer_a_clk_on_o     = gates.timer_a;

    // write strobes per lane and register, used by the checks below
    logic wr_fast0;
    logic wr_fast1;
    logic wr_sec1;

    assign wr_fast0 = fire && pwrite_i && sel[0] && pstrb_i[0];
    assign wr_fast1 = fire && pwrite_i && sel[0] && pstrb_i[1];
    assign wr_sec1  = fire && pwrite_i && sel[1] && pstrb_i[1];

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);

    a_conv_gate: assert property (
        wr_fast0 || wr_fast1 |-> ##2 converter_clk_on_o ==
            $past(st_d.fast[`PCG_CONVERTER_BIT], 2))
        else $error("converter enable does not follow its bit");

    a_conv_write: assert property (
        wr_fast1 |-> ##2 converter_clk_on_o ==
            $past(pwdata_i[`PCG_CONVERTER_BIT], 2))
        else $error("converter enable ignores a write");

    a_div_gate: assert property (
        wr_fast0 |-> ##2 divider_clk_on_o ==
            $past(pwdata_i[`PCG_DIVIDER_BIT], 2))
        else $error("divider enable ignores a write");

    a_crc_gate: assert property (
        wr_fast0 |-> ##2 checksum_clk_on_o ==
            $past(pwdata_i[`PCG_CHECKSUM_BIT], 2))
        else $error("checksum enable ignores a write");

    a_root_gate: assert property (
        wr_fast0 |-> ##2 root_unit_clk_on_o ==
            $past(pwdata_i[`PCG_ROOT_BIT], 2))
        else $error("square-root enable ignores a write");

    a_flash_gate: assert property (
        wr_fast0 |-> ##2 flash_if_clk_on_o ==
            $past(pwdata_i[`PCG_FLASH_BIT], 2))
        else $error("flash enable ignores a write");

    a_ram_sleep: assert property (
        sleep_i && !st_q.fast[`PCG_RAM_SLEEP_BIT]
            |=> !ram_clk_on_o)
        else $error("ram clock runs in sleep while disabled");

    a_ram_awake: assert property (
        !sleep_i || st_q.fast[`PCG_RAM_SLEEP_BIT] |=> ram_clk_on_o)
        else $error("ram clock stopped while it should run");

    a_dma_gate: assert property (
        wr_fast0 |-> ##2 dma_clk_on_o ==
            $past(pwdata_i[`PCG_DMA_BIT], 2))
        else $error("dma enable ignores a write");

    a_serial_gate: assert property (
        wr_sec1 |-> ##2 serial_port_one_clk_on_o ==
            $past(pwdata_i[`PCG_SERIAL_BIT], 2))
        else $error("serial port enable ignores a write");

    a_timer_b_gate: assert property (
        wr_sec1 |-> ##2 adv_timer_b_clk_on_o ==
            $past(pwdata_i[`PCG_TIMER_B_BIT], 2))
        else $error("timer b enable ignores a write");

    a_timer_a_gate: assert property (
        wr_sec1 |-> ##2 adv_timer_a_clk_on_o ==
            $past(pwdata_i[`PCG_TIMER_A_BIT], 2))
        else $error("timer a enable ignores a write");

    a_gates_stable: assert property (
        !fire ##1 !fire |=> $stable(dma_clk_on_o)
            && $stable(adv_timer_a_clk_on_o)
            && $stable(converter_clk_on_o))
        else $error("an enable moved without a write");

    a_reserved_zero: assert property (
        (st_q.fast & ~`PCG_FAST_MASK) == 32'h0
            && (st_q.second & ~`PCG_SECOND_MASK) == 32'h0)
        else $error("a reserved bit left its reset value");

    a_read_back: assert property (
        fire && pwrite_i && sel[0] && pstrb_i == 4'hf
            ##1 psel_i && !penable_i && !pwrite_i && sel[0]
            |=> prdata_o == ($past(pwdata_i, 2) & `PCG_FAST_MASK))
        else $error("fast register reads back a wrong value");

    a_reset_value: assert property (
        @(posedge clock_i) $fell(rst_i) |->
            flash_if_clk_on_o && ram_clk_on_o && !dma_clk_on_o
            && !converter_clk_on_o && !adv_timer_a_clk_on_o
            && st_q.fast == `PCG_FAST_RST)
        else $error("wrong state after reset");

    a_ready_time: assert property (
        psel_i && !penable_i && !st_q.ready |=> pready_o)
        else $error("no answer in the first access cycle");

    a_ready_one: assert property (
        fire |=> !pready_o)
        else $error("ready stayed high after the access");

    a_err_unmapped: assert property (
        psel_i && !penable_i && !st_q.ready && sel == 2'h0
            |=> pslverr_o && prdata_o == 32'h0)
        else $error("unmapped address answered without error");

    a_err_no_write: assert property (
        fire && pslverr_o |=> $stable(st_q.fast)
            && $stable(st_q.second))
        else $error("an erroneous access changed a register");

    // reads leave both registers alone
    a_read_no_write: assert property (
        fire && !pwrite_i |=> $stable(st_q.fast)
            && $stable(st_q.second))
        else $error("a read changed a register");

    // a lane whose strobe is off keeps its old bits
    a_lane_keep0: assert property (
        fire && pwrite_i && sel[0] && !pstrb_i[0]
            |=> st_q.fast[7:0] == $past(st_q.fast[7:0]))
        else $error("fast lane 0 changed with its strobe off");

    a_lane_keep1: assert property (
        fire && pwrite_i && sel[0] && !pstrb_i[1]
            |=> st_q.fast[15:8] == $past(st_q.fast[15:8]))
        else $error("fast lane 1 changed with its strobe off");

    a_sec_lane: assert property (
        fire && pwrite_i && sel[1] && !pstrb_i[1]
            |=> $stable(st_q.second))
        else $error("second register changed with lane 1 off");

    a_sec_read_back: assert property (
        fire && pwrite_i && sel[1] && pstrb_i == 4'hf
            ##1 psel_i && !penable_i && !pwrite_i && sel[1]
            |=> prdata_o == ($past(pwdata_i, 2) & `PCG_SECOND_MASK))
        else $error("second register reads back a wrong value");

    a_gates_steady: assert property (
        !fire ##1 !fire |=> $stable(divider_clk_on_o)
            && $stable(checksum_clk_on_o)
            && $stable(root_unit_clk_on_o)
            && $stable(flash_if_clk_on_o)
            && $stable(serial_port_one_clk_on_o)
            && $stable(adv_timer_b_clk_on_o))
        else $error("an enable moved with no write");

    // bus answer shape: no stray ready, no error or data on good writes
    a_ready_sel: assert property (
        !psel_i |=> !pready_o)
        else $error("ready raised without a select");

    a_err_mapped: assert property (
        psel_i && !penable_i && !st_q.ready && sel != 2'h0
            |=> !pslverr_o)
        else $error("mapped address answered with an error");

    a_write_rdata: assert property (
        psel_i && !penable_i && !st_q.ready && pwrite_i
            |=> prdata_o == 32'h0)
        else $error("a write answered with read data");

endmodule

// ---- tb_pcg_clock_gate.sv ----
/*
 * self-checking bench for the peripheral clock gating block: walks
 * every enable bit through APB, checks reset values, reserved bits,
 * byte strobes, unmapped addresses, the sleep case and a second reset.
 * assumes pcg_pkg, pcg_gate_if, pcg_gate_stage and pcg_clock_gate
 * are compiled first; the bench is the only APB master.
 */
`timescale 1ns/1ps
module tb_pcg_clock_gate;
    localparam logic [11:0] FAST_A = 12'h014;
    localparam logic [11:0] SEC_A  = 12'h018;
    localparam logic [31:0] FAST_M = 32'h0000_10f5;
    localparam logic [31:0] SEC_M  = 32'h0000_7000;

    logic        clock_i;
    logic        rst_i;
    logic        psel_i;
    logic        penable_i;
    logic        pwrite_i;
    logic [11:0] paddr_i;
    logic [31:0] pwdata_i;
    logic [3:0]  pstrb_i;
    logic [31:0] prdata_o;
    logic        pready_o;
    logic        pslverr_o;
    logic        sleep_i;
    logic [9:0]  gates;
    logic [31:0] fast_m;
    logic [31:0] second_m;
    logic [31:0] rd;
    logic        err;
    int          miscompares;
    int          checks_done;
    int          cycles;
    int          bits_f [7] = '{12, 7, 6, 5, 4, 2, 0};
    int          bits_s [3] = '{14, 13, 12};

    pcg_clock_gate uut
    (
        .clock_i                  (clock_i),
        .rst_i                    (rst_i),
        .psel_i                   (psel_i),
        .penable_i                (penable_i),
        .pwrite_i                 (pwrite_i),
        .paddr_i                  (paddr_i),
        .pwdata_i                 (pwdata_i),
        .pstrb_i                  (pstrb_i),
        .prdata_o                 (prdata_o),
        .pready_o                 (pready_o),
        .pslverr_o                (pslverr_o),
        .sleep_i                  (sleep_i),
        .converter_clk_on_o       (gates[9]),
        .divider_clk_on_o         (gates[8]),
        .checksum_clk_on_o        (gates[7]),
        .root_unit_clk_on_o       (gates[6]),
        .flash_if_clk_on_o        (gates[5]),
        .ram_clk_on_o             (gates[4]),
        .dma_clk_on_o             (gates[3]),
        .serial_port_one_clk_on_o (gates[2]),
        .adv_timer_b_clk_on_o     (gates[1]),
        .adv_timer_a_clk_on_o     (gates[0])
    );

    always #10 clock_i = ~clock_i;

    // a hang in a wait loop must still reach the verdict
    always @(posedge clock_i)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            miscompares++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // expected enables worked out from the bit positions themselves
    function automatic logic [9:0] exp_gates(input logic [31:0] f,
                                             input logic [31:0] s,
                                             input logic        slp);
        return {f[12], f[7], f[6], f[5], f[4], ~slp | f[2], f[0],
                s[14], s[13], s[12]};
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] o,
                                          input logic [31:0] w,
                                          input logic [3:0]  st,
                                          input logic [31:0] m);
        logic [31:0] be;
        be = {{8{st[3]}}, {8{st[2]}}, {8{st[1]}}, {8{st[0]}}};
        return ((o & ~be) | (w & be)) & m;
    endfunction

    // setup phase, driven just after a rising edge
    task automatic apb_setup(input logic wr, input logic [11:0] a,
                             input logic [31:0] wd, input logic [3:0] st);
        psel_i    <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i  <= wr;
        paddr_i   <= a;
        pwdata_i  <= wd;
        pstrb_i   <= st;
    endtask

    // access phase; the answer is read at the edge that samples it,
    // before the design's flops move; the loop waits for ready with no limit of its own, so a hang ends only at the timeout
    task automatic apb_access();
        int n;
        n = 0;
        @(posedge clock_i);
        penable_i <= 1'b1;
        do
        begin
            @(posedge clock_i);
            n++;
        end
        while (!pready_o);
        rd  = prdata_o;
        err = pslverr_o;
        check(n, 32'h1); // answer in the first access cycle
    endtask

    // one APB transfer, then the bus is released
    task automatic xfer(input logic wr, input logic [11:0] a,
                        input logic [31:0] wd, input logic [3:0] st);
        @(posedge clock_i);
        apb_setup(wr, a, wd, st);
        apb_access();
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
    endtask

    // write, then read with the read setup right after the access
    task automatic wr_rd(input logic [11:0] a, input logic [31:0] d);
        @(posedge clock_i);
        apb_setup(1'b1, a, d, 4'hf);
        apb_access();
        apb_setup(1'b0, a, 32'h0, 4'h0);
        apb_access();
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
        if (a == FAST_A)
            fast_m = d & FAST_M;
        else
            second_m = d & SEC_M;
        check(rd, (a == FAST_A) ? fast_m : second_m);
    endtask

    task automatic wr_reg(input logic [11:0] a, input logic [31:0] d,
                          input logic [3:0] st);
        xfer(1'b1, a, d, st);
        check({31'h0, err}, 32'h0);
        if (a == FAST_A)
            fast_m = merge(fast_m, d, st, FAST_M);
        else
            second_m = merge(second_m, d, st, SEC_M);
    endtask

    task automatic chk_all();
        xfer(1'b0, FAST_A, 32'h0, 4'h0);
        check(rd, fast_m);
        xfer(1'b0, SEC_A, 32'h0, 4'h0);
        check(rd, second_m);
        @(negedge clock_i);
        check({22'h0, gates}, {22'h0, exp_gates(fast_m, second_m, sleep_i)});
    endtask

    initial
    begin
        clock_i = 1'b0;
        rst_i = 1'b1;
        psel_i = 1'b0;
        penable_i = 1'b0;
        pwrite_i = 1'b0;
        paddr_i = 12'h000;
        pwdata_i = 32'h0;
        pstrb_i = 4'h0;
        sleep_i = 1'b0;
        miscompares = 0;
        checks_done = 0;
        cycles = 0;
        fast_m = 32'h0000_0014;
        second_m = 32'h0000_0000;
        repeat (10) @(negedge clock_i);
        check({22'h0, gates}, {22'h0, exp_gates(fast_m, second_m, 1'b0)});
        repeat (10) @(posedge clock_i);
        rst_i <= 1'b0;
        chk_all();
        $display("test reset values done");

        for (int i = 0; i < 7; i++)
        begin
            wr_reg(FAST_A, 32'h1 << bits_f[i], 4'hf);
            chk_all();
        end
        for (int i = 0; i < 3; i++)
        begin
            wr_reg(SEC_A, 32'h1 << bits_s[i], 4'hf);
            chk_all();
        end
        $display("test single enables done");

        wr_reg(FAST_A, 32'hffff_ffff, 4'hf);
        wr_reg(SEC_A, 32'hffff_ffff, 4'hf);
        chk_all();
        wr_reg(FAST_A, 32'h0, 4'hf);
        wr_reg(SEC_A, 32'h0, 4'hf);
        chk_all();
        $display("test all bits done");

        wr_reg(FAST_A, 32'hffff_ffff, 4'h2);
        wr_reg(FAST_A, 32'h0, 4'h1);
        chk_all();
        wr_reg(SEC_A, 32'hffff_ffff, 4'hd);
        chk_all();
        $display("test byte strobes done");

        @(posedge clock_i);
        sleep_i <= 1'b1;
        chk_all();
        wr_reg(FAST_A, 32'h0000_0004, 4'hf);
        chk_all();
        sleep_i <= 1'b0;
        wr_reg(FAST_A, 32'h0, 4'hf);
        chk_all();
        $display("test sleep done");

        wr_rd(FAST_A, 32'h0000_10a1);
        wr_rd(SEC_A, 32'h0000_5000);
        chk_all();
        $display("test back to back done");

        xfer(1'b1, 12'h01c, 32'hffff_ffff, 4'hf);
        check({31'h0, err}, 32'h1);
        xfer(1'b0, 12'h010, 32'h0, 4'h0);
        check({31'h0, err}, 32'h1);
        check(rd, 32'h0);
        chk_all();
        $display("test unmapped done");

        wr_reg(SEC_A, 32'h0000_7000, 4'hf);
        @(posedge clock_i);
        rst_i <= 1'b1;
        fast_m = 32'h0000_0014;
        second_m = 32'h0000_0000;
        repeat (3) @(negedge clock_i);
        check({22'h0, gates}, {22'h0, exp_gates(fast_m, second_m, 1'b0)});
        @(posedge clock_i);
        rst_i <= 1'b0;
        chk_all();
        $display("test second reset done");
        print_verdict();
    end
endmodule
